// [rtl/tfss_pkg.sv]
// constants, carriers and timing figures of the token frame send sequencer
// assumes one 250 MHz system clock; every user of it imports tfss_pkg::*
// Function
// - no pending data: send token frame alone
// - separate token: one cyclic frame, then token
// - separate token: all cyclic fragments, then token
// - message only: message first, then pass token
// - separate token: message, cyclic, then token
// - message, every cyclic fragment, token last
// - attached token rides in final cyclic frame
// - attached: message, then cyclic frame with token
// - wait minimum frame interval before each frame
// - one network interval, largest among participating nodes
// - split cyclic data above per-frame byte limit
// - three missed token frames mark node separated
// - 100 Mbps hold time formula
// - 10 Mbps hold time formula
// - second variant hold time formula
// - interval above hold time: refresh from frames
// - refresh interval is maximum of node settings
// - take token only when destination is own node
package tfss_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NODE_W = 8;
  localparam int INTV_W = 8;
  localparam int BYTE_W = 16;
  localparam int FRAG_W = 8;
  localparam int TIME_W = 32;

  // ----------------------------------------------------------------
  // timing: clock period and interval step, cycles derived
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint INTV_STEP_PS = 100000000; // 0.1 ms per setting step
  localparam int INTV_STEP_CYCLES =
    int'((INTV_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // framing and separation figures
  // ----------------------------------------------------------------
  localparam logic [BYTE_W:0] FRAME_LIMIT_BYTES = 17'h00400;
  localparam int FRAME_LIMIT_SHIFT = 10;
  localparam logic [1:0] MISS_LIMIT = 2'h3;

  // ----------------------------------------------------------------
  // hold time terms in units of 0.0001 ms
  // ----------------------------------------------------------------
  localparam logic [TIME_W-1:0] HOLD_BASE_100 = 32'h000032C8; // 1.3
  localparam logic [TIME_W-1:0] HOLD_WORD_100 = 32'h00000016; // 0.0022
  localparam logic [TIME_W-1:0] HOLD_BASE_10 = 32'h00004268; // 1.7
  localparam logic [TIME_W-1:0] HOLD_WORD_10 = 32'h00000020; // 0.0032
  localparam logic [TIME_W-1:0] HOLD_BASE_V2 = 32'h000034BC; // 1.35
  localparam logic [TIME_W-1:0] HOLD_WORD_V2 = 32'h00000020; // 0.0032
  // one setting step divided by ten in ms is 0.1 ms = 1000 units
  localparam logic [TIME_W-1:0] INTV_STEP_UNITS = 32'h000003E8;

  // ----------------------------------------------------------------
  // frame kinds and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_TOKEN  = 2'b00,
    KIND_CYCLIC = 2'b01,
    KIND_MSG    = 2'b10
  } tfss_kind_t;

  typedef struct packed {
    logic valid;
    logic [NODE_W-1:0] src;
    logic [NODE_W-1:0] dst;
  } tfss_tok_t;

  typedef struct packed {
    tfss_kind_t kind;
    logic tokenAttached;
    logic [FRAG_W-1:0] fragIdx;
    logic fragLast;
    logic [NODE_W-1:0] destNode;
  } tfss_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GAP  = 2'b01,
    ST_SEND = 2'b10,
    ST_DONE = 2'b11
  } tfss_state_t;

endpackage

// [rtl/tfss_sep_monitor.sv]
// per-node separation monitor: counts consecutive missed token frames
// assumes token events and rotation ticks come from clk_sys logic
`timescale 1ns/1ps
module tfss_sep_monitor
  import tfss_pkg::*;
#(
  parameter int NODE_CNT = 255
)
(
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic tokSeen, // a token frame was received
  input wire logic [NODE_W-1:0] tokSrc, // sender of that frame
  input wire logic roundTick, // one rotation finished
  input wire logic tokTimeout, // holder overran monitoring time
  input wire logic [NODE_W-1:0] holderNode, // node believed to hold token
  input wire logic [NODE_CNT-1:0] memberMask, // participating nodes
  output logic [NODE_CNT-1:0] separated // separated node flags
);

  // ----------------------------------------------------------------
  // one entry per node number
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NODE_CNT; i++)
    begin : gNode
      logic sent_q, sent_d;
      logic [1:0] miss_q, miss_d;
      logic sep_q, sep_d;
      logic hit, missEvt;

      // a sighting wins over a miss in the same cycle
      always_comb
      begin
        hit = tokSeen && (tokSrc == NODE_W'(i));
        missEvt = (roundTick && memberMask[i] && !sent_q) ||
                  (tokTimeout && (holderNode == NODE_W'(i)));
        sent_d = roundTick ? 1'b0 : sent_q;
        miss_d = miss_q;
        sep_d = sep_q;
        if (hit)
        begin
          sent_d = 1'b1;
          miss_d = 2'h0;
          sep_d = 1'b0;
        end
        else if (missEvt && miss_q != MISS_LIMIT)
        begin
          miss_d = miss_q + 2'h1;
          sep_d = (miss_q + 2'h1) == MISS_LIMIT;
        end
      end

      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          sent_q <= 1'b0;
          miss_q <= 2'h0;
          sep_q <= 1'b0;
        end
        else
        begin
          sent_q <= sent_d;
          miss_q <= miss_d;
          sep_q <= sep_d;
        end
      end

      assign separated[i] = sep_q;
    end
  endgenerate

endmodule

// [rtl/tfss_hold_calc.sv]
// token hold time and interval-bound refresh cycle calculator
// assumes inputs are steady for a cycle; results are registered
`timescale 1ns/1ps
module tfss_hold_calc
  import tfss_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic speed100, // 1: 100 Mbps, 0: 10 Mbps
  input wire logic variant2, // second module variant
  input wire logic [BYTE_W-1:0] cycBytes, // local cyclic bytes
  input wire logic [FRAG_W-1:0] localFrames, // local cyclic frames
  input wire logic [INTV_W-1:0] netInterval, // interval, 0.1 ms steps
  input wire logic [15:0] totalFrames, // frames of whole network
  output logic [TIME_W-1:0] holdTime, // 0.0001 ms units
  output logic [TIME_W-1:0] refreshCycleTime, // 0.0001 ms units
  output logic rcFromInterval // refresh bound by interval
);

  logic [TIME_W-1:0] hold_q, hold_d;
  logic [TIME_W-1:0] rc_q, rc_d;
  logic rcInt_q, rcInt_d;
  logic [TIME_W-1:0] base, perWord, words, intvUnits, gaps;

  // ----------------------------------------------------------------
  // formulas; words are bytes over two, interval steps are 0.1 ms
  // ----------------------------------------------------------------
  always_comb
  begin
    if (variant2)
    begin
      base = HOLD_BASE_V2;
      perWord = HOLD_WORD_V2;
    end
    else if (speed100)
    begin
      base = HOLD_BASE_100;
      perWord = HOLD_WORD_100;
    end
    else
    begin
      base = HOLD_BASE_10;
      perWord = HOLD_WORD_10;
    end
    words = TIME_W'(cycBytes >> 1);
    intvUnits = TIME_W'(netInterval) * INTV_STEP_UNITS;
    gaps = (localFrames == '0) ? '0 : TIME_W'(localFrames - FRAG_W'(1));
    hold_d = base + words * perWord + gaps * intvUnits;
    // interval longer than hold time: refresh set by frame gaps
    rcInt_d = intvUnits > hold_d;
    rc_d = rcInt_d ? TIME_W'(totalFrames) * intvUnits : '0;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_q <= '0;
      rc_q <= '0;
      rcInt_q <= 1'b0;
    end
    else
    begin
      hold_q <= hold_d;
      rc_q <= rc_d;
      rcInt_q <= rcInt_d;
    end
  end

  assign holdTime = hold_q;
  assign refreshCycleTime = rc_q;
  assign rcFromInterval = rcInt_q;

endmodule

// [rtl/tfss_top.sv]
// token frame send sequencer: orders message, cyclic and token frames
// assumes received token frames, pending flags and the frame sender
// all live on clk_sys; the sender pulses txDone when a frame has left
`timescale 1ns/1ps
module tfss_top
  import tfss_pkg::*;
#(
  parameter int NODE_CNT = 255,
  parameter int STEP_CYCLES = INTV_STEP_CYCLES
)
(
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic resetn, // async reset, active low
  input wire logic [NODE_W-1:0] ownNode, // local node number
  input wire logic [NODE_W-1:0] nextNode, // token successor
  input wire logic attachMode, // 1: token rides in last cyclic
  input wire logic speed100, // 1: 100 Mbps link
  input wire logic variant2, // second module variant
  input wire logic [INTV_W-1:0] intvSetting, // own interval, 0.1 ms
  input wire logic peerIntvValid, // peer interval report strobe
  input wire logic [INTV_W-1:0] peerIntv, // peer interval setting
  input wire logic memberChange, // node joined or left
  input wire logic [NODE_CNT-1:0] memberMask, // participating nodes
  input wire tfss_tok_t rxTok, // received token frame
  input wire logic tokTimeout, // token monitoring time expired
  input wire logic cycPending, // cyclic data waiting
  input wire logic [BYTE_W-1:0] cycBytes, // cyclic data size
  input wire logic msgPending, // message frame waiting
  input wire logic [15:0] totalFrames, // frames of whole network
  output logic txValid, // frame request to sender
  output tfss_frame_t txFrame, // frame descriptor
  input wire logic txReady, // sender takes the request
  input wire logic txDone, // frame fully transmitted
  output logic tokenHeld, // node holds the token
  output logic [INTV_W-1:0] netInterval, // network interval
  output logic [TIME_W-1:0] holdTime, // hold time, 0.0001 ms
  output logic [TIME_W-1:0] refreshCycleTime, // refresh, 0.0001 ms
  output logic rcFromInterval, // refresh bound by interval
  output logic [NODE_CNT-1:0] separated // separated node flags
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tfss_state_t state_q, state_d;
  logic msgLeft_q, msgLeft_d;
  logic [FRAG_W-1:0] cycLeft_q, cycLeft_d;
  logic [FRAG_W-1:0] cycTotal_q, cycTotal_d;
  logic tokLeft_q, tokLeft_d;
  logic [TIME_W-1:0] gapCnt_q, gapCnt_d;
  logic txValid_q, txValid_d;
  tfss_frame_t frame_q, frame_d;
  logic held_q, held_d;
  logic [INTV_W-1:0] netIntv_q, netIntv_d;
  logic [NODE_W-1:0] holder_q, holder_d;

  logic [FRAG_W-1:0] fragsNow;
  logic [BYTE_W:0] bytesRound;
  logic tokForUs;
  logic [TIME_W-1:0] gapLoad;
  tfss_frame_t pick;

  // ----------------------------------------------------------------
  // cyclic fragment count: ceiling of size over frame limit
  // ----------------------------------------------------------------
  always_comb
  begin
    bytesRound = {1'b0, cycBytes} + FRAME_LIMIT_BYTES - 17'h00001;
    fragsNow = '0;
    if (cycPending)
    begin
      fragsNow = FRAG_W'(bytesRound >> FRAME_LIMIT_SHIFT);
      if (fragsNow == '0)
        fragsNow = FRAG_W'(1); // empty cyclic area still sends a frame
    end
  end

  // only a token addressed to us makes us the holder
  assign tokForUs = rxTok.valid && (rxTok.dst == ownNode);

  // gap in cycles; a zero setting still costs one cycle
  assign gapLoad = TIME_W'(netIntv_q) * TIME_W'(STEP_CYCLES);

  // ----------------------------------------------------------------
  // next frame: message first, then cyclic fragments, token last
  // ----------------------------------------------------------------
  always_comb
  begin
    pick = '0;
    pick.destNode = nextNode;
    if (msgLeft_q)
    begin
      pick.kind = KIND_MSG;
    end
    else if (cycLeft_q != '0)
    begin
      pick.kind = KIND_CYCLIC;
      pick.fragIdx = cycTotal_q - cycLeft_q;
      pick.fragLast = (cycLeft_q == FRAG_W'(1));
      // attached mode: final fragment carries the token
      pick.tokenAttached = attachMode && pick.fragLast;
    end
    else
    begin
      pick.kind = KIND_TOKEN;
      pick.fragLast = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // network interval: restart from own value on membership change,
  // then keep the largest reported by participating peers
  // ----------------------------------------------------------------
  always_comb
  begin
    netIntv_d = netIntv_q;
    if (memberChange)
      netIntv_d = intvSetting;
    else if (peerIntvValid && peerIntv > netIntv_q)
      netIntv_d = peerIntv;
    if (!memberChange && intvSetting > netIntv_d)
      netIntv_d = intvSetting;
  end

  // ----------------------------------------------------------------
  // send sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    msgLeft_d = msgLeft_q;
    cycLeft_d = cycLeft_q;
    cycTotal_d = cycTotal_q;
    tokLeft_d = tokLeft_q;
    gapCnt_d = gapCnt_q;
    txValid_d = txValid_q;
    frame_d = frame_q;
    held_d = held_q;
    holder_d = holder_q;
    // track the current holder for timeout blame
    if (rxTok.valid)
      holder_d = rxTok.dst;
    unique case (state_q)
      ST_IDLE:
      begin
        // a token seen while busy is ignored; one token per turn
        if (tokForUs)
        begin
          held_d = 1'b1;
          msgLeft_d = msgPending;
          cycLeft_d = fragsNow;
          cycTotal_d = fragsNow;
          // attached mode with cyclic data needs no separate token
          tokLeft_d = !(attachMode && cycPending);
          gapCnt_d = gapLoad;
          state_d = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // hold off until the minimum frame interval has elapsed
        if (gapCnt_q <= TIME_W'(1))
        begin
          frame_d = pick;
          txValid_d = 1'b1;
          state_d = ST_SEND;
        end
        else
          gapCnt_d = gapCnt_q - TIME_W'(1);
      end
      ST_SEND:
      begin
        if (txReady)
        begin
          txValid_d = 1'b0;
          // retire the launched frame from the plan
          unique case (frame_q.kind)
            KIND_MSG: msgLeft_d = 1'b0;
            KIND_CYCLIC: cycLeft_d = cycLeft_q - FRAG_W'(1);
            default: tokLeft_d = 1'b0;
          endcase
          if (frame_q.tokenAttached)
            tokLeft_d = 1'b0;
          state_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // the token goes only after the frame has left the wire
        if (txDone)
        begin
          if (!msgLeft_q && cycLeft_q == '0 && !tokLeft_q)
          begin
            held_d = 1'b0;
            state_d = ST_IDLE;
          end
          else
          begin
            gapCnt_d = gapLoad;
            state_d = ST_GAP;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      msgLeft_q <= 1'b0;
      cycLeft_q <= '0;
      cycTotal_q <= '0;
      tokLeft_q <= 1'b0;
      gapCnt_q <= '0;
      txValid_q <= 1'b0;
      frame_q <= '0;
      held_q <= 1'b0;
      holder_q <= '0;
      netIntv_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      msgLeft_q <= msgLeft_d;
      cycLeft_q <= cycLeft_d;
      cycTotal_q <= cycTotal_d;
      tokLeft_q <= tokLeft_d;
      gapCnt_q <= gapCnt_d;
      txValid_q <= txValid_d;
      frame_q <= frame_d;
      held_q <= held_d;
      holder_q <= holder_d;
      netIntv_q <= netIntv_d;
    end
  end

  assign txValid = txValid_q;
  assign txFrame = frame_q;
  assign tokenHeld = held_q;
  assign netInterval = netIntv_q;

  // ----------------------------------------------------------------
  // timing figures and separation tracking
  // ----------------------------------------------------------------
  tfss_hold_calc uCalc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .speed100(speed100),
    .variant2(variant2),
    .cycBytes(cycBytes),
    .localFrames(fragsNow),
    .netInterval(netIntv_q),
    .totalFrames(totalFrames),
    .holdTime(holdTime),
    .refreshCycleTime(refreshCycleTime),
    .rcFromInterval(rcFromInterval)
  );

  // a rotation ends each time the token reaches this node
  tfss_sep_monitor #(.NODE_CNT(NODE_CNT)) uSep (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tokSeen(rxTok.valid),
    .tokSrc(rxTok.src),
    .roundTick(tokForUs),
    .tokTimeout(tokTimeout),
    .holderNode(holder_q),
    .memberMask(memberMask),
    .separated(separated)
  );

endmodule

// [bench/tfss_sender_model.sv]
// far-side model: frame sender handshake and a peer node's reports
// assumes clk_sys domain; announce is a one-cycle pulse from the bench
`timescale 1ns/1ps
module tfss_sender_model
  import tfss_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic slow, // 1: stall before taking and on the wire
  input wire logic txValid, // frame request from the sequencer
  input wire logic announce, // peer reports its interval now
  input wire logic [INTV_W-1:0] peerSet, // peer interval setting
  output logic txReady, // request taken
  output logic txDone, // frame left the wire
  output logic peerIntvValid, // peer report strobe
  output logic [INTV_W-1:0] peerIntv // peer report value
);
  // ------------
  // sender and peer
  // ------------
  int waitCnt;
  int wireCnt;

  // one frame in flight at a time, like a single real transmitter
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      txReady <= 1'b0;
      txDone <= 1'b0;
      peerIntvValid <= 1'b0;
      peerIntv <= '0;
      waitCnt <= 0;
      wireCnt <= 0;
    end
    else
    begin
      txReady <= 1'b0;
      txDone <= 1'b0;
      // peer keeps the shared interval rule by reporting its own setting
      peerIntvValid <= announce;
      // no stale report value stands
      peerIntv <= announce ? peerSet : ~peerIntv;
      if (wireCnt > 0)
      begin
        wireCnt <= wireCnt - 1;
        txDone <= (wireCnt == 1);
      end
      else if (txValid && !txReady)
      begin
        if (waitCnt == 0)
        begin
          txReady <= 1'b1;
          wireCnt <= slow ? 9 : 3;
          waitCnt <= slow ? int'($urandom % 4) : 0;
        end
        else
          waitCnt <= waitCnt - 1;
      end
    end
  end
endmodule

// [bench/tfss_top_chk.sv]
// port checker for the token frame send sequencer
// assumes it is bound into tfss_top; one clock, async low reset
`timescale 1ns/1ps
module tfss_top_chk
  import tfss_pkg::*;
#(
  parameter int NODE_CNT = 8,
  parameter int STEP_CYCLES = 4
)
(
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [NODE_W-1:0] ownNode, // local node
  input wire logic [NODE_W-1:0] nextNode, // successor
  input wire logic attachMode, // attached variant
  input wire logic peerIntvValid, // peer report
  input wire logic [INTV_W-1:0] peerIntv, // peer setting
  input wire logic memberChange, // join or leave
  input wire tfss_tok_t rxTok, // received token
  input wire logic txValid, // frame request
  input wire tfss_frame_t txFrame, // frame descriptor
  input wire logic txReady, // sender take
  input wire logic txDone, // frame left
  input wire logic tokenHeld, // token held
  input wire logic [INTV_W-1:0] netInterval, // network interval
  input wire logic [TIME_W-1:0] refreshCycleTime, // refresh
  input wire logic rcFromInterval, // refresh from interval
  input wire logic [NODE_CNT-1:0] separated // separated flags
);
  // ------------
  // gap counter
  // ------------
  int gapCnt_q;
  int gapCnt_d;
  logic heldPrev_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // restart whenever the next frame's gap begins
  always_comb
  begin
    gapCnt_d = gapCnt_q + 1;
    if ((tokenHeld && !heldPrev_q) || txDone)
      gapCnt_d = 0;
  end

  // registers only; small slack absorbs the launch edge
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      gapCnt_q <= 0;
      heldPrev_q <= 1'b0;
    end
    else
    begin
      gapCnt_q <= gapCnt_d;
      heldPrev_q <= tokenHeld;
    end
  end

  // ------------
  // assertions
  // ------------
  chk_tok_take: assert property (
    rxTok.valid && rxTok.dst == ownNode && !tokenHeld |=> tokenHeld)
    else $error("token for own node not taken");
  chk_tok_foreign: assert property (
    rxTok.valid && rxTok.dst != ownNode && !tokenHeld |=> !tokenHeld)
    else $error("token for other node taken");
  chk_gap_min: assert property (
    $rose(txValid) |-> gapCnt_q + 2 >= int'(netInterval) * STEP_CYCLES)
    else $error("frame launched before interval");
  chk_req_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txFrame))
    else $error("request dropped or changed before taken");
  chk_dest_next: assert property (
    txValid |-> txFrame.destNode == nextNode)
    else $error("frame not aimed at successor");
  chk_attach_last: assert property (
    txValid && txFrame.tokenAttached |->
      txFrame.kind == KIND_CYCLIC && txFrame.fragLast)
    else $error("token attached to wrong frame");
  chk_sep_attach: assert property (
    txValid && !attachMode |-> !txFrame.tokenAttached)
    else $error("token attached in separate variant");
  chk_send_held: assert property (
    txValid |-> tokenHeld)
    else $error("frame sent without token");
  chk_rc_zero: assert property (
    !rcFromInterval |-> refreshCycleTime == '0)
    else $error("refresh given while not interval bound");
  chk_net_max: assert property (
    peerIntvValid && !memberChange |=> netInterval >= $past(peerIntv))
    else $error("network interval below peer report");
  chk_sep_clear: assert property (
    rxTok.valid && rxTok.src < NODE_CNT |=> !separated[$past(rxTok.src)])
    else $error("seen node still separated");

  cover property (txValid && txReady && txFrame.tokenAttached);
  cover property (rcFromInterval);
  cover property (|separated);
endmodule

bind tfss_top tfss_top_chk #(.NODE_CNT(NODE_CNT),
  .STEP_CYCLES(STEP_CYCLES)) tfss_top_chk_i (.*);

// [bench/tfss_top_tb_top.sv]
// self-checking bench for the token frame send sequencer
// assumes the sender model and the bound checker
`timescale 1ns/1ps
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tfss_top_tb_top
  import tfss_pkg::*;
();
  // ------------
  // signals and instances
  // ------------
  logic clk_sys, resetn, attachMode, speed100, variant2, slow, announce;
  logic peerIntvValid, memberChange, tokTimeout, cycPending, msgPending;
  logic txValid, txReady, txDone, tokenHeld, rcFromInterval;
  logic [7:0] ownNode, nextNode, intvSetting, peerIntv, peerSet, netInterval;
  logic [15:0] cycBytes, totalFrames;
  logic [31:0] holdTime, refreshCycleTime;
  logic [7:0] separated, memberMask;
  tfss_tok_t rxTok;
  tfss_frame_t txFrame;
  logic [19:0] expQ[$];
  logic [19:0] ex;
  int checks = 0;
  int n_fail = 0;

  tfss_top #(.NODE_CNT(8), .STEP_CYCLES(4)) tfss_top_i (.*);

  tfss_sender_model tfss_sender_model_i (.*);

  // compared frame fields
  function automatic logic [19:0] pk(input tfss_kind_t k, input logic a,
    input logic [7:0] ix, input logic l, input logic [7:0] d);
    return {k, a, ix, l, d};
  endfunction

  // ------------
  // tasks
  // ------------
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tok(input logic [7:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    rxTok <= {1'b1, s, d};
    @(posedge clk_sys);
    rxTok <= '0;
  endtask

  task automatic mchg;
    @(posedge clk_sys);
    memberChange <= 1'b1;
    @(posedge clk_sys);
    memberChange <= 1'b0;
  endtask

  task automatic annc(input logic [7:0] v);
    @(posedge clk_sys);
    peerSet <= v;
    announce <= 1'b1;
    @(posedge clk_sys);
    announce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // queue expected frames, pass token, wait for release
  task automatic run_seq(input logic s, a, m, c, input int b);
    int fr;
    int n;
    fr = c ? (b + 1023) / 1024 : 0;
    if (m)
      expQ.push_back(pk(KIND_MSG, 1'b0, 8'h00, 1'b0, nextNode));
    for (int i = 0; i < fr; i++)
      expQ.push_back(pk(KIND_CYCLIC, a && i == fr - 1, 8'(i),
        i == fr - 1, nextNode));
    if (!(a && c))
      expQ.push_back(pk(KIND_TOKEN, 1'b0, 8'h00, 1'b0, nextNode));
    @(posedge clk_sys);
    slow <= s;
    attachMode <= a;
    msgPending <= m;
    cycPending <= c;
    cycBytes <= 16'(b);
    tok(8'h02, 8'h01);
    #1;
    `CMP(tokenHeld, 1'b1)
    n = 0;
    while (tokenHeld === 1'b1 && n < 4000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CMP(expQ.size(), 0)
  endtask

  // ------------
  // clock, watchdog, monitor
  // ------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // about ninety times the run
  initial
  begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  // transfer: request and take both high
  always @(negedge clk_sys)
  begin
    if (resetn && txValid === 1'b1 && txReady === 1'b1)
    begin
      `CMP(expQ.size() > 0, 1'b1)
      ex = (expQ.size() > 0) ? expQ.pop_front() : 20'hFFFFF;
      `CMP(pk(txFrame.kind, txFrame.tokenAttached, txFrame.kind ==
        KIND_CYCLIC ? txFrame.fragIdx : 8'h00, txFrame.kind ==
        KIND_CYCLIC && txFrame.fragLast, txFrame.destNode), ex)
    end
  end

  // ------------
  // main sequence
  // ------------
  initial
  begin
    int tbl[10][5];
    int b;
    int tf;
    logic [31:0] e;
    logic [31:0] hb[3];
    logic [31:0] hw[3];
    // rows: attached, message, cyclic, bytes low, bytes high
    tbl = '{'{0, 0, 0, 0, 0}, '{0, 0, 1, 1024, 1024},
      '{0, 0, 1, 1025, 2048}, '{0, 1, 0, 0, 0}, '{0, 1, 1, 1, 1024},
      '{0, 1, 1, 2049, 3072}, '{1, 0, 1, 1025, 4096},
      '{1, 1, 1, 1, 1024}, '{1, 0, 0, 0, 0}, '{1, 1, 0, 0, 0}};
    hb = '{32'h32C8, 32'h4268, 32'h34BC};
    hw = '{32'h16, 32'h20, 32'h20};
    void'($urandom(32'h33D5));
    {resetn, attachMode, speed100, variant2, slow, announce} = '0;
    {memberChange, tokTimeout, cycPending, msgPending} = '0;
    {cycBytes, totalFrames, peerSet, memberMask} = '0;
    rxTok = '0;
    ownNode = 8'h01;
    intvSetting = 8'h02;
    speed100 = 1'b1;
    nextNode = 8'(2 + $urandom % 6);
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    mchg();
    // every ordering pattern, both variants, prompt and slow sender
    for (int i = 0; i < 10; i++)
    begin
      b = tbl[i][3] + int'($urandom % (tbl[i][4] - tbl[i][3] + 1));
      run_seq(i[0], tbl[i][0][0], tbl[i][1][0], tbl[i][2][0], b);
    end
    // separation: a foreign token is not taken, then node 3 falls silent
    memberMask <= 8'h0E;
    tok(8'h03, 8'h04);
    #1;
    `CMP(tokenHeld, 1'b0)
    for (int r = 0; r < 4; r++)
    begin
      run_seq(1'b0, 1'b0, 1'b0, 1'b0, 0);
      `CMP(separated[3], r == 3)
    end
    tok(8'h03, 8'h04);
    @(posedge clk_sys);
    #1;
    `CMP(separated[3:2], 2'b00)
    // shared interval is the largest reported since the last change
    annc(8'h05);
    `CMP(netInterval, 8'h05)
    annc(8'h03);
    `CMP(netInterval, 8'h05)
    // hold time for each speed and variant, several fragments
    for (int m = 0; m < 3; m++)
    begin
      b = 1025 + int'($urandom % 3072);
      @(posedge clk_sys);
      speed100 <= (m == 0);
      variant2 <= (m == 2);
      cycPending <= 1'b1;
      cycBytes <= 16'(b);
      repeat (4) @(posedge clk_sys);
      #1;
      e = hb[m] + 32'(b / 2) * hw[m] + 32'((b + 1023) / 1024 - 1) * 32'h1388;
      `CMP(holdTime, e)
    end
    // interval larger than hold time binds the refresh cycle
    tf = 1 + int'($urandom % 50);
    @(posedge clk_sys);
    intvSetting <= 8'h14;
    totalFrames <= 16'(tf);
    cycBytes <= 16'h0064;
    speed100 <= 1'b1;
    variant2 <= 1'b0;
    mchg();
    repeat (5) @(posedge clk_sys);
    #1;
    `CMP(holdTime, 32'h3714)
    `CMP(rcFromInterval, 1'b1)
    `CMP(refreshCycleTime, 32'(tf) * 32'h4E20)
    @(posedge clk_sys);
    intvSetting <= 8'h02;
    mchg();
    repeat (5) @(posedge clk_sys);
    #1;
    `CMP(rcFromInterval, 1'b0)
    report_and_stop();
  end
endmodule
